/* File: t1p_pkg.sv */
/*
 * Shared constants of the timer-1 event flags and shared prescaler block:
 * register offsets, field positions, reset values, clock-select codes,
 * wave-mode codes and prescaler tap divisors.
 * Assumes an 8-bit register port driven by the processor core.
 */
package t1p_pkg;

   // Data-space offsets of the registers decoded here
   localparam logic [7:0] OFS_EVENT_FLAGS   = 8'h36;
   localparam logic [7:0] OFS_EVENT_ENABLES = 8'h6f;
   localparam logic [7:0] OFS_GENERAL_CTRL  = 8'h43;
   localparam logic [7:0] OFS_COUNT_HIGH    = 8'h85;
   localparam logic [7:0] OFS_CAPTURE_HIGH  = 8'h87;
   localparam logic [7:0] OFS_CMP_A_LOW     = 8'h88;
   localparam logic [7:0] OFS_CMP_A_HIGH    = 8'h89;
   localparam logic [7:0] OFS_CMP_B_LOW     = 8'h8a;
   localparam logic [7:0] OFS_CMP_B_HIGH    = 8'h8b;

   // Port-instruction offsets are data-space offsets minus this base
   localparam logic [7:0] IO_SPACE_BASE = 8'h20;
   localparam logic [7:0] IO_SPACE_MASK = 8'h3f;

   // Bit positions shared by the flag and enable registers
   localparam int BIT_CAPTURE   = 5;
   localparam int BIT_COMPARE_B = 2;
   localparam int BIT_COMPARE_A = 1;
   localparam int BIT_OVERFLOW  = 0;

   // Bit positions in the general control register
   localparam int BIT_SYNC_HOLD_MODE = 7;
   localparam int BIT_PRESCALER_RST  = 0;

   // Reset values
   localparam logic [7:0]  RST_EVENT_FLAGS   = 8'h00;
   localparam logic [7:0]  RST_EVENT_ENABLES = 8'h00;
   localparam logic [15:0] RST_COMPARE       = 16'h0000;

   // Clock source select codes
   localparam logic [2:0] CS_STOPPED  = 3'h0;
   localparam logic [2:0] CS_DIRECT   = 3'h1;
   localparam logic [2:0] CS_DIV8     = 3'h2;
   localparam logic [2:0] CS_DIV64    = 3'h3;
   localparam logic [2:0] CS_DIV256   = 3'h4;
   localparam logic [2:0] CS_DIV1024  = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // Prescaler taps, as counter low-bit widths (2^n divisors)
   localparam int PRESCALE_WIDTH = 10;
   localparam int TAP_DIV8       = 3;
   localparam int TAP_DIV64      = 6;
   localparam int TAP_DIV256     = 8;
   localparam int TAP_DIV1024    = 10;

   // Wave modes in which the overflow flag follows plain counter wrap
   localparam logic [3:0] WM_NORMAL      = 4'h0;
   localparam logic [3:0] WM_CLEAR_MATCH = 4'h4;
   localparam logic [3:0] WM_CLEAR_CAPT  = 4'hc;

endpackage

/* File: t1p_timer_events.sv */
/*
 * Timer-1 interrupt enables and event flags, compare-A/B match logic with
 * the shared high-byte holding register, the free-running prescaler shared
 * by both timers, and the external count pin synchronisers.
 * Assumes the counter core lives elsewhere: it supplies the count value and
 * capture/top/overflow events and consumes the timer clock enables made here.
 * Register port: single-cycle 8-bit reads and writes on core_clk.
 */
`timescale 1ns/10ps

// How it works
// - compare B against count each timer clock
// - high byte staged in shared holding register
// - enable register 0x6F, bits 5,2,1,0
// - request needs enable, global flag, status flag
// - flag register 0x36, port offset 0x16
// - port instructions decode offset minus 0x20
// - capture flag from pin or top
// - flags clear by vector or written one
// - compare flags set cycle after match
// - forced compare never sets match flag
// - overflow flag set in normal/clear modes
// - select 0x01 clocks at system rate
// - prescaler taps divide by 8/64/256/1024
// - one free prescaler shared, separate selects
// - first prescaled count within 1..N+1 cycles
// - prescaler reset restarts every timer's period
// - pin sampled by latch then register
// - select 7 rising, 6 falling edge pulses
// - pin edge to count 2.5-3.5 cycles
// - external clock bypasses the prescaler
// - prescaler reset bit self-clears unless hold
module t1p_timer_events #(
   parameter int CNT_WIDTH = 16 // Timer-1 count width
) (
   input  wire logic                 core_clk,         // System I/O clock
   input  wire logic                 rst_b,            // Async reset
   input  wire logic [7:0]           regAddr,          // Register offset
   input  wire logic                 ioSpace,          // Port-instr access
   input  wire logic                 regWrite,         // Write strobe
   input  wire logic                 regRead,          // Read strobe
   input  wire logic [7:0]           regWrData,        // Write data
   output logic      [7:0]           regRdData,        // Read data
   input  wire logic                 globalIntEnable,  // Core I flag
   input  wire logic [3:0]           vectorTaken,      // Vector executed
   input  wire logic [2:0]           clockSourceSel1,  // Timer-1 select
   input  wire logic [2:0]           clockSourceSel0,  // Timer-0 select
   input  wire logic [3:0]           waveModeSelect,   // Timer-1 wave mode
   input  wire logic [CNT_WIDTH-1:0] timerCountValue,  // Counter value
   input  wire logic                 captureEvent,     // Capture pin event
   input  wire logic                 captureTopEvent,  // Reached top
   input  wire logic                 counterWrap,      // Normal overflow
   input  wire logic                 pwmOverflowEvent, // PWM-mode overflow
   input  wire logic                 forceCompareA,    // Forced compare A
   input  wire logic                 forceCompareB,    // Forced compare B
   input  wire logic                 countPinTimerWide,   // Timer-1 pin
   input  wire logic                 countPinTimerNarrow, // Timer-0 pin
   output logic                      timer1Tick,       // Timer-1 clk enable
   output logic                      timer0Tick,       // Timer-0 clk enable
   output logic [3:0]                irqRequest,       // Requests, flag bits
   output logic                      compareAWaveOut,  // A match pulse
   output logic                      compareBWaveOut,  // B match pulse
   output logic [7:0]                timer1EventFlags, // Flag register
   output logic                      prescalerInReset  // Prescaler held
);

   // Clock-enable mux shared by both timers; the external edge input
   // never passes through the prescaler, so no divided edge exists
   function automatic logic pickTick(
      input logic [2:0] sel,
      input logic       p8,
      input logic       p64,
      input logic       p256,
      input logic       p1024,
      input logic       rise,
      input logic       fall
   );
      logic t;
      t = 1'b0;
      unique case (sel)
         t1p_pkg::CS_STOPPED:  t = 1'b0;
         t1p_pkg::CS_DIRECT:   t = 1'b1;
         t1p_pkg::CS_DIV8:     t = p8;
         t1p_pkg::CS_DIV64:    t = p64;
         t1p_pkg::CS_DIV256:   t = p256;
         t1p_pkg::CS_DIV1024:  t = p1024;
         t1p_pkg::CS_EXT_FALL: t = fall;
         t1p_pkg::CS_EXT_RISE: t = rise;
      endcase
      return t;
   endfunction

   // Register state
   logic [7:0]           enables_reg;       // Event enables
   logic [7:0]           flags_reg;         // Event flags
   logic                 syncHold_reg;      // Synchronisation hold mode
   logic                 prescRst_reg;      // Prescaler reset bit
   logic [7:0]           tempHigh_reg;      // Shared high-byte holder
   logic [CNT_WIDTH-1:0] compareA_reg;      // Compare A value
   logic [CNT_WIDTH-1:0] compareB_reg;      // Compare B value
   logic [t1p_pkg::PRESCALE_WIDTH-1:0] presc_reg; // Prescaler count
   logic                 matchA_reg;        // Match seen, flag next tick
   logic                 matchB_reg;

   // Pin synchronisers: latch, register, edge history
   logic wideLatch;
   logic narrowLatch;
   logic wideSync_reg;
   logic narrowSync_reg;
   logic widePrev_reg;
   logic narrowPrev_reg;

   // Address decode; port instructions see offsets 0x00..0x3F
   wire logic [7:0] ioAddr  = (regAddr & t1p_pkg::IO_SPACE_MASK)
                              + t1p_pkg::IO_SPACE_BASE;
   wire logic [7:0] effAddr = ioSpace ? ioAddr : regAddr;
   wire logic wrFlags   = regWrite && effAddr == t1p_pkg::OFS_EVENT_FLAGS;
   wire logic wrEnables = regWrite
                          && effAddr == t1p_pkg::OFS_EVENT_ENABLES;
   wire logic wrGeneral = regWrite
                          && effAddr == t1p_pkg::OFS_GENERAL_CTRL;
   wire logic wrCmpALow = regWrite && effAddr == t1p_pkg::OFS_CMP_A_LOW;
   wire logic wrCmpBLow = regWrite && effAddr == t1p_pkg::OFS_CMP_B_LOW;
   // Any 16-bit high byte lands in the one shared holder
   wire logic wrHigh = regWrite
                       && (effAddr == t1p_pkg::OFS_COUNT_HIGH
                        || effAddr == t1p_pkg::OFS_CAPTURE_HIGH
                        || effAddr == t1p_pkg::OFS_CMP_A_HIGH
                        || effAddr == t1p_pkg::OFS_CMP_B_HIGH);

   // Only the implemented bits exist; the rest read as zero
   localparam logic [7:0] EVENT_MASK = 8'h01 << t1p_pkg::BIT_CAPTURE
                                     | 8'h01 << t1p_pkg::BIT_COMPARE_B
                                     | 8'h01 << t1p_pkg::BIT_COMPARE_A
                                     | 8'h01 << t1p_pkg::BIT_OVERFLOW;

   // Prescaler taps: one-cycle pulse when the low n bits are all ones
   wire logic presc8    = &presc_reg[t1p_pkg::TAP_DIV8-1:0];
   wire logic presc64   = &presc_reg[t1p_pkg::TAP_DIV64-1:0];
   wire logic presc256  = &presc_reg[t1p_pkg::TAP_DIV256-1:0];
   wire logic presc1024 = &presc_reg[t1p_pkg::TAP_DIV1024-1:0];

   // Edge detectors look only at the second stage and its history
   wire logic wideRise   = wideSync_reg & ~widePrev_reg;
   wire logic wideFall   = ~wideSync_reg & widePrev_reg;
   wire logic narrowRise = narrowSync_reg & ~narrowPrev_reg;
   wire logic narrowFall = ~narrowSync_reg & narrowPrev_reg;

   wire logic tick1Next = pickTick(clockSourceSel1, presc8, presc64,
                                   presc256, presc1024, wideRise,
                                   wideFall);
   wire logic tick0Next = pickTick(clockSourceSel0, presc8, presc64,
                                   presc256, presc1024, narrowRise,
                                   narrowFall);

   // Compare on each timer clock; the flag follows one tick later
   wire logic eqA = timerCountValue == compareA_reg;
   wire logic eqB = timerCountValue == compareB_reg;

   // Capture flag source depends on whether capture defines top
   wire logic captureIsTop = waveModeSelect[3] && !waveModeSelect[0];
   wire logic setCapture = captureIsTop ? captureTopEvent
                                        : captureEvent;
   wire logic plainWrapMode = waveModeSelect == t1p_pkg::WM_NORMAL
                           || waveModeSelect == t1p_pkg::WM_CLEAR_MATCH
                           || waveModeSelect == t1p_pkg::WM_CLEAR_CAPT;
   wire logic setOverflow = plainWrapMode ? counterWrap
                                          : pwmOverflowEvent;

   // Match flags land on the timer clock after the equal one; forced
   // compares only reach the wave outputs
   wire logic setCmpA = timer1Tick && matchA_reg;
   wire logic setCmpB = timer1Tick && matchB_reg;

   wire logic [7:0] flagSet = ({7'h00, setOverflow}
                                 << t1p_pkg::BIT_OVERFLOW)
                            | ({7'h00, setCmpA} << t1p_pkg::BIT_COMPARE_A)
                            | ({7'h00, setCmpB} << t1p_pkg::BIT_COMPARE_B)
                            | ({7'h00, setCapture}
                                 << t1p_pkg::BIT_CAPTURE);
   wire logic [7:0] vectorClr = ({7'h00, vectorTaken[0]}
                                   << t1p_pkg::BIT_OVERFLOW)
                              | ({7'h00, vectorTaken[1]}
                                   << t1p_pkg::BIT_COMPARE_A)
                              | ({7'h00, vectorTaken[2]}
                                   << t1p_pkg::BIT_COMPARE_B)
                              | ({7'h00, vectorTaken[3]}
                                   << t1p_pkg::BIT_CAPTURE);
   wire logic [7:0] flagClr = vectorClr
                            | (wrFlags ? regWrData : 8'h00);
   // A set arriving with its clear wins, so no event is lost
   wire logic [7:0] flags_next = ((flags_reg & ~flagClr) | flagSet)
                                 & EVENT_MASK;

   // Prescaler reset bit: written ones clear at once unless held
   wire logic [7:0] genWr = regWrData;
   wire logic prescRst_next = wrGeneral
        ? (genWr[t1p_pkg::BIT_PRESCALER_RST]
           && genWr[t1p_pkg::BIT_SYNC_HOLD_MODE])
        : (prescRst_reg && syncHold_reg);
   // Reset pulse from a write, or the level kept in hold mode
   wire logic prescRstNow = (wrGeneral
                             && genWr[t1p_pkg::BIT_PRESCALER_RST])
                          || prescRst_reg;

   wire logic [7:0] irqFlat = enables_reg & flags_reg
                            & {8{globalIntEnable}};
   wire logic [3:0] irqNext = {irqFlat[t1p_pkg::BIT_CAPTURE],
                               irqFlat[t1p_pkg::BIT_COMPARE_B],
                               irqFlat[t1p_pkg::BIT_COMPARE_A],
                               irqFlat[t1p_pkg::BIT_OVERFLOW]};

   // Read mux
   wire logic [7:0] rdNext =
        effAddr == t1p_pkg::OFS_EVENT_FLAGS   ? flags_reg :
        effAddr == t1p_pkg::OFS_EVENT_ENABLES ? enables_reg :
        effAddr == t1p_pkg::OFS_GENERAL_CTRL
           ? ({7'h00, syncHold_reg} << t1p_pkg::BIT_SYNC_HOLD_MODE)
           | ({7'h00, prescRst_reg} << t1p_pkg::BIT_PRESCALER_RST) :
        effAddr == t1p_pkg::OFS_CMP_A_LOW  ? compareA_reg[7:0] :
        effAddr == t1p_pkg::OFS_CMP_A_HIGH ? compareA_reg[15:8] :
        effAddr == t1p_pkg::OFS_CMP_B_LOW  ? compareB_reg[7:0] :
        effAddr == t1p_pkg::OFS_CMP_B_HIGH ? compareB_reg[15:8] : 8'h00;

   // Pin latches, transparent while the clock is high; the half cycle
   // they add gives the fractional part of the pin-to-count delay
   always_latch begin
      if (core_clk) begin
         wideLatch   = countPinTimerWide;
         narrowLatch = countPinTimerNarrow;
      end
   end

   // Pin sampling registers and edge history
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wideSync_reg   <= 1'b0;
         narrowSync_reg <= 1'b0;
         widePrev_reg   <= 1'b0;
         narrowPrev_reg <= 1'b0;
      end else begin
         wideSync_reg   <= wideLatch;
         narrowSync_reg <= narrowLatch;
         widePrev_reg   <= wideSync_reg;
         narrowPrev_reg <= narrowSync_reg;
      end
   end

   // Shared prescaler: free running, restarted for both timers at once
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         presc_reg <= '0;
      end else if (prescRstNow) begin
         presc_reg <= '0;
      end else begin
         presc_reg <= presc_reg + 1'b1;
      end
   end

   // Prescaler control bits
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         syncHold_reg <= 1'b0;
         prescRst_reg <= 1'b0;
      end else begin
         if (wrGeneral) begin
            syncHold_reg <= genWr[t1p_pkg::BIT_SYNC_HOLD_MODE];
         end
         prescRst_reg <= prescRst_next;
      end
   end

   // Enable and flag registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         enables_reg <= t1p_pkg::RST_EVENT_ENABLES;
         flags_reg   <= t1p_pkg::RST_EVENT_FLAGS;
      end else begin
         if (wrEnables) begin
            enables_reg <= regWrData & EVENT_MASK;
         end
         flags_reg <= flags_next;
      end
   end

   // Compare values update both bytes together on the low-byte write
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tempHigh_reg <= 8'h00;
         compareA_reg <= t1p_pkg::RST_COMPARE;
         compareB_reg <= t1p_pkg::RST_COMPARE;
      end else begin
         if (wrHigh) begin
            tempHigh_reg <= regWrData;
         end
         if (wrCmpALow) begin
            compareA_reg <= {tempHigh_reg, regWrData};
         end
         if (wrCmpBLow) begin
            compareB_reg <= {tempHigh_reg, regWrData};
         end
      end
   end

   // Match capture and registered outputs
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         matchA_reg       <= 1'b0;
         matchB_reg       <= 1'b0;
         timer1Tick       <= 1'b0;
         timer0Tick       <= 1'b0;
         compareAWaveOut  <= 1'b0;
         compareBWaveOut  <= 1'b0;
         irqRequest       <= 4'h0;
         regRdData        <= 8'h00;
         timer1EventFlags <= 8'h00;
         prescalerInReset <= 1'b0;
      end else begin
         if (timer1Tick) begin
            matchA_reg <= eqA;
            matchB_reg <= eqB;
         end
         timer1Tick       <= tick1Next;
         timer0Tick       <= tick0Next;
         compareAWaveOut  <= setCmpA || forceCompareA;
         compareBWaveOut  <= setCmpB || forceCompareB;
         irqRequest       <= irqNext;
         if (regRead) begin
            regRdData <= rdNext;
         end
         timer1EventFlags <= flags_next;
         prescalerInReset <= prescRstNow;
      end
   end

   // Checks kept beside the logic they guard
   a_irq_gating: assert property (@(posedge core_clk) disable iff (!rst_b)
      irqRequest[0] |-> $past(enables_reg[0] && flags_reg[0]
                              && globalIntEnable))
      else $error("overflow request without enable and flag");

   a_flag_w1c: assert property (@(posedge core_clk) disable iff (!rst_b)
      (wrFlags && regWrData[0] && !setOverflow) |=> !flags_reg[0])
      else $error("written one did not clear overflow flag");

   a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
      (setCapture && vectorTaken[3]) |=> flags_reg[5])
      else $error("capture set lost against its clear");

   a_cmp_flag_tick: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      $rose(flags_reg[1]) |-> $past(timer1Tick && matchA_reg))
      else $error("compare A flag set off its timer clock");

   a_force_noflag: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (forceCompareB && !setCmpB && !flags_reg[2] && !vectorTaken[2])
        |=> !flags_reg[2])
      else $error("forced compare B raised its flag");

   a_presc_clear: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (wrGeneral && genWr[0] && !genWr[7]) |=> !prescRst_reg
        && presc_reg == '0)
      else $error("prescaler reset bit did not self clear");

   a_direct_rate: assert property (@(posedge core_clk)
      disable iff (!rst_b)
      (clockSourceSel1 == t1p_pkg::CS_DIRECT) |=> timer1Tick)
      else $error("direct select missed a system clock");

   a_halt_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clockSourceSel1 == t1p_pkg::CS_STOPPED) |=> !timer1Tick)
      else $error("timer ticked while stopped");

   a_div8_tap: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clockSourceSel0 == t1p_pkg::CS_DIV8 && !prescRstNow && presc8)
        ##1 (clockSourceSel0 == t1p_pkg::CS_DIV8) [*7]
        |-> !timer0Tick)
      else $error("divide-by-8 tap ticked early");

   a_ext_rise: assert property (@(posedge core_clk) disable iff (!rst_b)
      (clockSourceSel1 == t1p_pkg::CS_EXT_RISE && wideSync_reg
        && !widePrev_reg) |=> timer1Tick)
      else $error("rising pin edge gave no timer clock");

endmodule

/* File: t1p_pin_source.sv */
/* Far-side model: an external clock source on the timer-1 count pin.
   Assumes the bench raises run on a clock edge and idles the pin low. */
`timescale 1ns/10ps
module t1p_pin_source (
   input  wire logic run, // Emit whole periods while high
   output logic      pin  // Count pin, rests low between bursts
);
   // Uneven halves put rises 3 ns after a sampling clock edge; falls land on one
   initial begin
      pin = 1'b0;
      forever begin
         wait (run);
         #23 pin = 1'b1;
         #27 pin = 1'b0;
      end
   end
endmodule

/* File: tb_top.sv */
/* Self-checking bench for the timer-1 flags and shared prescaler.
   Assumes t1p_pkg, the design and the pin source model come first. */
`timescale 1ns/10ps
module tb_top;
   logic        core_clk, rst_b, ioSpace, regWrite, regRead;
   logic        globalIntEnable, captureEvent, captureTopEvent;
   logic        counterWrap, pwmOverflowEvent, forceCompareA;
   logic        forceCompareB, countPinTimerWide, countPinTimerNarrow;
   logic        timer1Tick, timer0Tick, compareAWaveOut, pinRun;
   logic        compareBWaveOut, prescalerInReset;
   logic [7:0]  regAddr, regWrData, regRdData, timer1EventFlags;
   logic [3:0]  vectorTaken, waveModeSelect, irqRequest;
   logic [2:0]  clockSourceSel1, clockSourceSel0;
   logic [15:0] timerCountValue;
   int          error_cnt, check_count, n1, n0, edges;
   int          exp1[6] = '{0, 1024, 128, 16, 4, 1}; // Ticks per 1024

   t1p_timer_events u_t1p_timer_events (.core_clk, .rst_b, .regAddr,
      .ioSpace, .regWrite, .regRead, .regWrData, .regRdData,
      .globalIntEnable, .vectorTaken, .clockSourceSel1, .clockSourceSel0,
      .waveModeSelect, .timerCountValue, .captureEvent, .captureTopEvent,
      .counterWrap, .pwmOverflowEvent, .forceCompareA, .forceCompareB,
      .countPinTimerWide, .countPinTimerNarrow, .timer1Tick, .timer0Tick,
      .irqRequest, .compareAWaveOut, .compareBWaveOut, .timer1EventFlags,
      .prescalerInReset);
   t1p_pin_source u_t1p_pin_source (.run(pinRun), .pin(countPinTimerWide));

   // Clock and a count of every pin edge
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(countPinTimerWide) edges++;

   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", what, exp, got);
      end
   endtask

   // Strobe held over one taken edge, dropped after it
   task automatic wr(input logic [7:0] a, d, input logic io);
      @(posedge core_clk);
      regWrite  <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      ioSpace   <= io;
      @(posedge core_clk);
      regWrite  <= 1'b0;
   endtask

   // Read data is registered on the taken edge, checked one cycle later
   task automatic rd(input logic [7:0] a, exp, input string what);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      ioSpace <= 1'b0;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(posedge core_clk);
      #1 chk(what, {8'h00, exp}, {8'h00, regRdData});
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // Accumulates clock enables of both timers
   task automatic count(input int cyc);
      repeat (cyc) begin
         @(negedge core_clk);
         n1 += 32'(timer1Tick);
         n0 += 32'(timer0Tick);
      end
   endtask

   // A hang ends the run as a failure
   initial begin
      #200us;
      error_cnt++;
      stop_test();
   end

   initial begin
      {rst_b, ioSpace, regWrite, regRead, globalIntEnable} = '0;
      {captureEvent, captureTopEvent, counterWrap, pwmOverflowEvent} = '0;
      {forceCompareA, forceCompareB, countPinTimerNarrow, pinRun} = '0;
      {regAddr, regWrData, vectorTaken, waveModeSelect} = '0;
      clockSourceSel1 = t1p_pkg::CS_STOPPED;
      clockSourceSel0 = t1p_pkg::CS_STOPPED;
      timerCountValue = 16'hffff; // Matches neither compare register
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(8'h36, 8'h00, "flags reset");
      rd(8'h6f, 8'h00, "enables reset");
      wr(8'h6f, 8'hff, 1'b0);
      rd(8'h6f, 8'h27, "enables");
      rd(8'h50, 8'h00, "unmapped");
      // Capture with the global flag off, then on
      @(posedge core_clk) captureEvent <= 1'b1;
      @(posedge core_clk) captureEvent <= 1'b0;
      tick(2);
      chk("irq masked", 16'h0, {12'h0, irqRequest});
      chk("capture flag", 16'h20, {8'h0, timer1EventFlags});
      @(posedge core_clk) globalIntEnable <= 1'b1;
      tick(2);
      chk("irq capture", 16'h8, {12'h0, irqRequest});
      wr(8'h16, 8'h20, 1'b1);
      rd(8'h36, 8'h00, "capture cleared");
      // Overflow in normal mode, cleared by its vector
      @(posedge core_clk) counterWrap <= 1'b1;
      @(posedge core_clk) counterWrap <= 1'b0;
      tick(1);
      chk("overflow flag", 16'h01, {8'h0, timer1EventFlags});
      @(posedge core_clk) vectorTaken <= 4'h1;
      @(posedge core_clk) vectorTaken <= 4'h0;
      tick(1);
      chk("vector clear", 16'h00, {8'h0, timer1EventFlags});
      // Capture event meeting its own vector clear: the set must win
      @(posedge core_clk) {captureEvent, vectorTaken} <= {1'b1, 4'h8};
      @(posedge core_clk) {captureEvent, vectorTaken} <= '0;
      tick(1);
      chk("set wins", 16'h20, {8'h0, timer1EventFlags});
      wr(8'h36, 8'h20, 1'b0);
      // Compare B loaded through the shared high byte
      wr(8'h8b, 8'h12, 1'b0);
      wr(8'h8a, 8'h34, 1'b0);
      @(posedge core_clk) clockSourceSel1 <= t1p_pkg::CS_DIRECT;
      @(posedge core_clk) forceCompareB <= 1'b1;
      @(posedge core_clk) forceCompareB <= 1'b0;
      #1 chk("wave b", 16'h1, {15'h0, compareBWaveOut});
      tick(2);
      chk("forced", 16'h00, {8'h0, timer1EventFlags});
      @(posedge core_clk) timerCountValue <= 16'h1234;
      tick(3);
      chk("compare b", 16'h04, {8'h0, timer1EventFlags});
      chk("irq cmp b", 16'h4, {12'h0, irqRequest});
      @(posedge core_clk) timerCountValue <= 16'hffff;
      wr(8'h36, 8'h04, 1'b0);
      tick(1);
      chk("w1c", 16'h00, {8'h0, timer1EventFlags});
      // Every internal select, timer 0 fixed on the divide-by-256 tap
      @(posedge core_clk) clockSourceSel0 <= t1p_pkg::CS_DIV256;
      for (int s = 0; s < 6; s++) begin
         @(posedge core_clk) clockSourceSel1 <= 3'(s);
         tick(2);
         {n1, n0} = '0;
         count(1024);
         chk("tick1", 16'(exp1[s]), 16'(n1));
         chk("tick0", 16'd4, 16'(n0));
      end
      // Prescaler reset restarts both timers' periods
      wr(8'h43, 8'h01, 1'b0);
      rd(8'h43, 8'h00, "self clear");
      {n1, n0} = '0;
      count(1000);
      chk("tick1 restart", 16'd0, 16'(n1));
      chk("tick0 restart", 16'd3, 16'(n0));
      wr(8'h43, 8'h81, 1'b0);
      rd(8'h43, 8'h81, "hold");
      chk("presc held", 16'h1, {15'h0, prescalerInReset});
      @(posedge core_clk) clockSourceSel1 <= t1p_pkg::CS_DIV8;
      n1 = 0;
      count(50);
      chk("held", 16'd0, 16'(n1));
      wr(8'h43, 8'h00, 1'b0);
      rd(8'h43, 8'h00, "release");
      chk("presc run", 16'h0, {15'h0, prescalerInReset});
      @(posedge core_clk) clockSourceSel0 <= t1p_pkg::CS_DIV8;
      // External edges, select changed while the pin rests
      for (int s = 7; s > 5; s--) begin
         @(posedge core_clk) clockSourceSel1 <= 3'(s);
         tick(2);
         {n1, edges} = '0;
         @(posedge core_clk) pinRun <= 1'b1;
         count(100);
         @(posedge core_clk) pinRun <= 1'b0;
         count(12);
         chk("ext ticks", 16'(edges / 2), 16'(n1));
      end
      stop_test();
   end
endmodule
